// [uamf_consts.svh]
// Constants for the multiprocessor address filter
// How it works
// - In modes 2 and 3 with multiproc_enable set, a frame raises receive_flag and the interrupt only if its ninth bit is 1.
// - In modes 2 and 3 with multiproc_enable set, a frame whose ninth bit is 0 sets no receive_flag and gives no interrupt.
// - Every party in a multiprocessor exchange runs its port in mode 2 or 3 so a ninth bit is carried.
// - In mode 0 multiproc_enable has no effect on reception.
// - In mode 1 with multiproc_enable set, no receive interrupt is raised unless a valid stop bit ends the frame.
// - In modes 1 to 3 with multiproc_enable set, an address frame sets receive_flag only when it matches the given or broadcast address.
// - In mode 1 with matching on, the stop bit acts as ninth bit and the flag needs a match plus a valid stop bit.
// - The given address compares only bits where the mask holds 1 against the own address; mask zeros are don't-care.
// - The broadcast address is own address OR mask, and its zero bits are don't-care.
// - An address frame matching the broadcast address is accepted.
// - Reset clears own address and mask to zero so that any address is accepted.
// - Each of the two ports has its own address and mask pair and matches only against it.
`ifndef UAMF_CONSTS_SVH
`define UAMF_CONSTS_SVH
`define UAMF_ADDR_W         8
`define UAMF_DATA_W         8
`define UAMF_OFS_OWN0       8'ha9
`define UAMF_OFS_MASK0      8'hb9
`define UAMF_OFS_MASK1      8'hba
`define UAMF_OFS_OWN1       8'hbb
`define UAMF_OFS_CTRL0      8'hc0
`define UAMF_OFS_CTRL1      8'hc1
`define UAMF_OFS_STAT       8'hc4
`define UAMF_OFS_IMASK      8'hc5
`define UAMF_OFS_RDATA0     8'hc8
`define UAMF_OFS_RDATA1     8'hc9
`define UAMF_RST_BYTE       8'h00
`define UAMF_CTRL_MPE_BIT   2
`define UAMF_CTRL_MODE_LSB  0
`define UAMF_STAT_FLAG0_BIT 0
`define UAMF_STAT_FLAG1_BIT 1
`define UAMF_STAT_ADDR0_BIT 2
`define UAMF_STAT_ADDR1_BIT 3
`define UAMF_STAT_W         4
`endif

// [uamf_line_master.sv]
// Model of the other stations on the shared serial line
`timescale 1ns/1ps
module uamf_line_master
    import uamf_pkg::*;
(
    // Clock
    input  wire logic        clk_in,
    // Frames to the two receive ports
    output logic             rx0_valid_out,
    output uamf_frame_s      rx0_frame_out,
    output logic             rx1_valid_out,
    output uamf_frame_s      rx1_frame_out
);
    // Line idle at time zero
    initial begin
        rx0_valid_out = 1'b0;
        rx1_valid_out = 1'b0;
        rx0_frame_out = '0;
        rx1_frame_out = '0;
    end
    // One frame, ninth bit always carried; released lines show the inverse
    task automatic send(input logic port, input logic [7:0] d, input logic ninth, input logic stop);
        uamf_frame_s f;
        f = {d, ninth, stop};
        @(posedge clk_in);
        rx0_frame_out <= f;
        rx1_frame_out <= f;
        rx0_valid_out <= !port;
        rx1_valid_out <= port;
        @(posedge clk_in);
        rx0_valid_out <= 1'b0;
        rx1_valid_out <= 1'b0;
        rx0_frame_out <= ~f;
        rx1_frame_out <= ~f;
    endtask : send
endmodule : uamf_line_master

// [uamf_pkg.sv]
// Types for the multiprocessor address filter
package uamf_pkg;
    typedef enum logic [1:0] {
        UAMF_MODE0 = 2'b00,
        UAMF_MODE1 = 2'b01,
        UAMF_MODE2 = 2'b10,
        UAMF_MODE3 = 2'b11
    } uamf_mode_e;

    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       stop_ok;
    } uamf_frame_s;

    typedef struct packed {
        logic       mpe;
        uamf_mode_e mode;
    } uamf_ctrl_s;
endpackage : uamf_pkg

// [uamf_port_filter.sv]
// One port's acceptance decision for a received frame
`timescale 1ns/1ps
`include "uamf_consts.svh"
module uamf_port_filter
    import uamf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Frame and settings
    input  wire logic        valid_in,
    input  wire uamf_frame_s frame_in,
    input  wire uamf_ctrl_s  ctrl_in,
    input  wire logic [7:0]  own_in,
    input  wire logic [7:0]  mask_in,
    // Decision
    output logic             accept_out,
    output logic             is_addr_out,
    output logic [7:0]       data_out
);
    logic       accept;
    logic       is_addr;
    logic [7:0] data;
    logic       next_accept;
    logic       next_is_addr;
    logic [7:0] next_data;
    logic       given_hit;
    logic       bcast_hit;
    logic [7:0] bcast;
    logic       ninth_eff;

    // Address comparison against this port's own pair
    always_comb begin
        bcast     = own_in | mask_in;
        given_hit = ((frame_in.data ^ own_in) & mask_in) == 8'h00;
        bcast_hit = ((frame_in.data ^ bcast) & bcast) == 8'h00;
    end

    // Acceptance decision per mode
    always_comb begin
        next_accept  = 1'b0;
        next_is_addr = is_addr;
        next_data    = data;
        ninth_eff    = frame_in.ninth;
        if (valid_in) begin
            case (ctrl_in.mode)
                UAMF_MODE0: begin
                    next_accept = 1'b1;
                end
                UAMF_MODE1: begin
                    ninth_eff = frame_in.stop_ok;
                    if (ctrl_in.mpe)
                        next_accept = ninth_eff && (given_hit || bcast_hit);
                    else
                        next_accept = 1'b1;
                end
                UAMF_MODE2, UAMF_MODE3: begin
                    if (ctrl_in.mpe)
                        next_accept = frame_in.ninth && (given_hit || bcast_hit);
                    else
                        next_accept = frame_in.stop_ok;
                end
                default: begin
                    next_accept = 1'b0;
                end
            endcase
            if (next_accept) begin
                next_data    = frame_in.data;
                next_is_addr = ninth_eff;
            end
        end
    end

    // Decision registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            accept  <= 1'b0;
            is_addr <= 1'b0;
            data    <= `UAMF_RST_BYTE;
        end else begin
            accept  <= next_accept;
            is_addr <= next_is_addr;
            data    <= next_data;
        end
    end

    assign accept_out  = accept;
    assign is_addr_out = is_addr;
    assign data_out    = data;
endmodule : uamf_port_filter

// [uamf_top.sv]
// Address filter for two receive ports with register port and interrupt
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "uamf_consts.svh"
module uamf_top
    import uamf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [7:0]       reg_rdata_out,
    // Received frames from the two shifters
    input  wire logic        rx0_valid_in,
    input  wire uamf_frame_s rx0_frame_in,
    input  wire logic        rx1_valid_in,
    input  wire uamf_frame_s rx1_frame_in,
    // Interrupt
    output logic             irq_out
);
    localparam int NPORT = 2;

    logic [7:0]             own   [NPORT];
    logic [7:0]             mask  [NPORT];
    uamf_ctrl_s             ctrl  [NPORT];
    logic [7:0]             next_own  [NPORT];
    logic [7:0]             next_mask [NPORT];
    uamf_ctrl_s             next_ctrl [NPORT];
    logic [`UAMF_STAT_W-1:0] stat;
    logic [`UAMF_STAT_W-1:0] imask;
    logic [`UAMF_STAT_W-1:0] next_stat;
    logic [`UAMF_STAT_W-1:0] next_imask;
    logic [7:0]             rdata;
    logic [7:0]             next_rdata;
    logic                   irq;
    logic                   next_irq;
    logic                   f_valid [NPORT];
    uamf_frame_s            f_frame [NPORT];
    logic                   acc     [NPORT];
    logic                   acc_addr[NPORT];
    logic [7:0]             acc_data[NPORT];
    logic [`UAMF_STAT_W-1:0] set_bits;

    assign f_valid[0] = rx0_valid_in;
    assign f_valid[1] = rx1_valid_in;
    assign f_frame[0] = rx0_frame_in;
    assign f_frame[1] = rx1_frame_in;

    // One filter per port, each with its own pair
    generate
        for (genvar p = 0; p < NPORT; p++) begin : g_port
            uamf_port_filter u_filt (
                .clk_in      (clk_in),
                .rst_in      (rst_in),
                .valid_in    (f_valid[p]),
                .frame_in    (f_frame[p]),
                .ctrl_in     (ctrl[p]),
                .own_in      (own[p]),
                .mask_in     (mask[p]),
                .accept_out  (acc[p]),
                .is_addr_out (acc_addr[p]),
                .data_out    (acc_data[p])
            );
        end
    endgenerate

    // Events from the filters
    always_comb begin
        set_bits = '0;
        set_bits[`UAMF_STAT_FLAG0_BIT] = acc[0];
        set_bits[`UAMF_STAT_FLAG1_BIT] = acc[1];
        set_bits[`UAMF_STAT_ADDR0_BIT] = acc[0] & acc_addr[0];
        set_bits[`UAMF_STAT_ADDR1_BIT] = acc[1] & acc_addr[1];
    end

    // Register writes, sticky status with set over clear
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            next_own[i]  = own[i];
            next_mask[i] = mask[i];
            next_ctrl[i] = ctrl[i];
        end
        next_imask = imask;
        next_stat  = stat;
        if (reg_wr_in) begin
            case (reg_addr_in)
                `UAMF_OFS_OWN0:  next_own[0]  = reg_wdata_in;
                `UAMF_OFS_MASK0: next_mask[0] = reg_wdata_in;
                `UAMF_OFS_OWN1:  next_own[1]  = reg_wdata_in;
                `UAMF_OFS_MASK1: next_mask[1] = reg_wdata_in;
                `UAMF_OFS_CTRL0: next_ctrl[0] = uamf_ctrl_s'(reg_wdata_in[`UAMF_CTRL_MPE_BIT:`UAMF_CTRL_MODE_LSB]);
                `UAMF_OFS_CTRL1: next_ctrl[1] = uamf_ctrl_s'(reg_wdata_in[`UAMF_CTRL_MPE_BIT:`UAMF_CTRL_MODE_LSB]);
                `UAMF_OFS_IMASK: next_imask   = reg_wdata_in[`UAMF_STAT_W-1:0];
                `UAMF_OFS_STAT:  next_stat    = stat & ~reg_wdata_in[`UAMF_STAT_W-1:0];
                default: begin
                end
            endcase
        end
        next_stat = next_stat | set_bits;
        next_irq  = |(next_stat & next_imask);
    end

    // Register reads, data one cycle later
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `UAMF_OFS_OWN0:   next_rdata = own[0];
                `UAMF_OFS_MASK0:  next_rdata = mask[0];
                `UAMF_OFS_OWN1:   next_rdata = own[1];
                `UAMF_OFS_MASK1:  next_rdata = mask[1];
                `UAMF_OFS_CTRL0:  next_rdata = {5'h00, ctrl[0]};
                `UAMF_OFS_CTRL1:  next_rdata = {5'h00, ctrl[1]};
                `UAMF_OFS_STAT:   next_rdata = {4'h0, stat};
                `UAMF_OFS_IMASK:  next_rdata = {4'h0, imask};
                `UAMF_OFS_RDATA0: next_rdata = acc_data[0];
                `UAMF_OFS_RDATA1: next_rdata = acc_data[1];
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < NPORT; i++) begin
                own[i]  <= `UAMF_RST_BYTE;
                mask[i] <= `UAMF_RST_BYTE;
                ctrl[i] <= '0;
            end
            stat  <= '0;
            imask <= '0;
            rdata <= `UAMF_RST_BYTE;
            irq   <= 1'b0;
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                own[i]  <= next_own[i];
                mask[i] <= next_mask[i];
                ctrl[i] <= next_ctrl[i];
            end
            stat  <= next_stat;
            imask <= next_imask;
            rdata <= next_rdata;
            irq   <= next_irq;
        end
    end

    assign reg_rdata_out = rdata;
    assign irq_out       = irq;
endmodule : uamf_top

// [uamf_top_monitor.sv]
// Checker of the address filter top ports
`timescale 1ns/1ps
`include "uamf_consts.svh"
module uamf_top_monitor
    import uamf_pkg::*;
(
    // Clock, reset and register port
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_rdata_out,
    // Frames and interrupt
    input  wire logic        rx0_valid_in,
    input  wire uamf_frame_s rx0_frame_in,
    input  wire logic        rx1_valid_in,
    input  wire uamf_frame_s rx1_frame_in,
    input  wire logic        irq_out
);
    logic [7:0] own;
    logic [7:0] msk;
    logic [2:0] ctl;
    logic       im;
    logic       hit;
    logic [7:0] bc;
    // Shadow of port 0 settings
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            own <= 8'h00;
            msk <= 8'h00;
            ctl <= 3'h0;
            im  <= 1'b0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `UAMF_OFS_OWN0) own <= reg_wdata_in;
            if (reg_addr_in == `UAMF_OFS_MASK0) msk <= reg_wdata_in;
            if (reg_addr_in == `UAMF_OFS_CTRL0) ctl <= reg_wdata_in[2:0];
            if (reg_addr_in == `UAMF_OFS_IMASK) im <= reg_wdata_in[0];
        end
    end
    // Given or broadcast hit
    assign bc  = own | msk;
    assign hit = (((rx0_frame_in.data ^ own) & msk) == 8'h00) || (((rx0_frame_in.data ^ bc) & bc) == 8'h00);
    sequence s_quiet;
        !irq_out && !reg_wr_in && !rx1_valid_in && !$past(rx0_valid_in) && !$past(rx1_valid_in);
    endsequence
    property p_acc(c);
        @(posedge clk_in) disable iff (rst_in) (rx0_valid_in && im && c) |-> ##2 irq_out;
    endproperty
    property p_rej(c);
        @(posedge clk_in) disable iff (rst_in) (rx0_valid_in && c) ##0 s_quiet ##1 !reg_wr_in |=> !irq_out;
    endproperty
    a_mode0_pass:
        assert property (p_acc(ctl[1:0] == 2'b00)) else $error("mode 0 frame not flagged");
    a_nompe_pass:
        assert property (p_acc(ctl[1] && !ctl[2] && rx0_frame_in.stop_ok)) else $error("frame not flagged");
    a_addr_hit:
        assert property (p_acc(ctl[1] && ctl[2] && rx0_frame_in.ninth && hit)) else $error("address hit lost");
    a_stop_hit:
        assert property (p_acc(ctl == 3'h5 && rx0_frame_in.stop_ok && hit)) else $error("mode 1 hit lost");
    a_data_block:
        assert property (p_rej(ctl[1] && ctl[2] && !rx0_frame_in.ninth)) else $error("data frame flagged");
    a_bad_stop:
        assert property (p_rej(ctl == 3'h5 && !rx0_frame_in.stop_ok)) else $error("bad stop flagged");
    a_addr_miss:
        assert property (p_rej(ctl[1] && ctl[2] && !hit)) else $error("address miss flagged");
    a_irq_reset:
        assert property (@(posedge clk_in) disable iff (rst_in) $past(rst_in) |-> !irq_out) else $error("irq after reset");
    a_own_read:
        assert property (@(posedge clk_in) disable iff (rst_in) (reg_rd_in && reg_addr_in == `UAMF_OFS_OWN0)
            |=> reg_rdata_out == own) else $error("own address readback wrong");
    a_rd_idle:
        assert property (@(posedge clk_in) disable iff (rst_in) !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
            else $error("read data outside read cycle");
endmodule : uamf_top_monitor

bind uamf_top uamf_top_monitor u_mon (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .rx0_valid_in(rx0_valid_in), .rx0_frame_in(rx0_frame_in), .rx1_valid_in(rx1_valid_in),
    .rx1_frame_in(rx1_frame_in), .irq_out(irq_out));

// [uart_multiproc_address_filter_tb.sv]
// Self-checking bench for the address filter
`timescale 1ns/1ps
`include "uamf_consts.svh"
module uart_multiproc_address_filter_tb
    import uamf_pkg::*;
;
    logic        clk_in;
    logic        rst_in;
    logic        reg_wr_in;
    logic        reg_rd_in;
    logic [7:0]  reg_addr_in;
    logic [7:0]  reg_wdata_in;
    logic [7:0]  reg_rdata_out;
    logic        rx0_valid_in;
    logic        rx1_valid_in;
    logic        irq_out;
    uamf_frame_s rx0_frame_in;
    uamf_frame_s rx1_frame_in;
    logic [27:0] e;
    int          error_cnt = 0;
    int          compares = 0;
    logic [7:0]  ofs [4] = '{`UAMF_OFS_OWN0, `UAMF_OFS_MASK0, `UAMF_OFS_MASK1, `UAMF_OFS_OWN1};
    // Port, control, data, ninth and stop, expected flags
    logic [27:0] tbl [12] = '{28'h006c035, 28'h006c235, 28'h006c130, 28'h006ff35, 28'h007c010, 28'h0033311,
        28'h0041201, 28'h0011201, 28'h005c020, 28'h005c015, 28'h106c13a, 28'h1075510};
    uamf_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rx0_valid_in(rx0_valid_in),
        .rx0_frame_in(rx0_frame_in), .rx1_valid_in(rx1_valid_in), .rx1_frame_in(rx1_frame_in), .irq_out(irq_out));
    uamf_line_master u_line (.clk_in(clk_in), .rx0_valid_out(rx0_valid_in), .rx0_frame_out(rx0_frame_in),
        .rx1_valid_out(rx1_valid_in), .rx1_frame_out(rx1_frame_in));
    // Clock
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 cmp(reg_rdata_out & m, exp);
    endtask : rd
    task automatic final_report;
        $display("Mismatches %0d, compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    // Hang guard
    initial begin
        #1000000;
        error_cnt++;
        final_report;
    end
    // Main sequence
    initial begin
        rst_in = 1'b1;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], 8'hff, 8'h00);
        rd(8'h10, 8'hff, 8'h00);
        foreach (ofs[i]) wr(ofs[i], 8'(i) + 8'h11);
        foreach (ofs[i]) rd(ofs[i], 8'hff, 8'(i) + 8'h11);
        wr(`UAMF_OFS_OWN0, 8'hc0);
        wr(`UAMF_OFS_MASK0, 8'hfd);
        wr(`UAMF_OFS_OWN1, 8'hc0);
        wr(`UAMF_OFS_MASK1, 8'hfe);
        wr(`UAMF_OFS_IMASK, 8'h03);
        foreach (tbl[i]) begin
            e = tbl[i];
            wr(`UAMF_OFS_CTRL0 | {7'h00, e[24]}, e[23:16]);
            u_line.send(e[24], e[15:8], e[5], e[4]);
            repeat (2) @(posedge clk_in);
            #1 cmp({7'h00, irq_out}, {7'h00, e[3:0] != 4'h0});
            rd(`UAMF_OFS_STAT, 8'h0f, {4'h0, e[3:0]});
            wr(`UAMF_OFS_STAT, 8'h0f);
        end
        // Masked event, then unmask and clear
        wr(`UAMF_OFS_IMASK, 8'h00);
        u_line.send(1'b0, 8'hc0, 1'b0, 1'b1);
        repeat (2) @(posedge clk_in);
        #1 cmp({7'h00, irq_out}, 8'h00);
        // Last accepted bytes, settings and the masked sticky status
        rd(`UAMF_OFS_RDATA0, 8'hff, 8'hc0);
        rd(`UAMF_OFS_RDATA1, 8'hff, 8'hc1);
        rd(`UAMF_OFS_CTRL1, 8'hff, 8'h07);
        rd(`UAMF_OFS_IMASK, 8'hff, 8'h00);
        rd(`UAMF_OFS_STAT, 8'hff, 8'h05);
        wr(`UAMF_OFS_IMASK, 8'h01);
        @(posedge clk_in);
        #1 cmp({7'h00, irq_out}, 8'h01);
        wr(`UAMF_OFS_STAT, 8'h0f);
        @(posedge clk_in);
        #1 cmp({7'h00, irq_out}, 8'h00);
        // Reset in mid-run brings both pairs back to zero
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], 8'hff, 8'h00);
        rd(`UAMF_OFS_CTRL0, 8'hff, 8'h00);
        rd(`UAMF_OFS_STAT, 8'hff, 8'h00);
        final_report;
    end
endmodule : uart_multiproc_address_filter_tb
